// File: inc/stp_defines.svh
// Named constants of the speech test serial port.
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

// Bits in one speech sample word.
`define STP_SAMPLE_W 13
// Samples per second in each direction.
`define STP_SAMPLE_RATE_HZ 8000
// Serial bit rate on each data line.
`define STP_BIT_RATE_HZ 104000
// Period of the link-side clock, in picoseconds (48 ns).
`define STP_LINK_CLK_PS 48000
// Link-clock cycles per half period of the data clock, rounded down.
`define STP_LINK_HALF \
  (int'(64'd1000000000000 / (64'd2 * `STP_BIT_RATE_HZ * `STP_LINK_CLK_PS)))
// Level of the data clock while no transfer runs.
`define STP_CLK_IDLE 1'b1
// Level of the internal-path select after reset.
`define STP_PATH_INTERNAL 1'b1

`endif

// File: inc/stp_link_if.sv
// Signals between the system-clock side and the link-clock side of the port.
`timescale 1ns/1ps
interface stp_link_if #(
  parameter int W = 13
);
  logic         run;
  logic         tx_dir;
  logic         rx_dir;
  logic         tx_tgl;
  logic [W-1:0] tx_word;
  logic         tx_ack;
  logic         rx_tgl;
  logic [W-1:0] rx_word;

  modport sys  (output run, tx_dir, rx_dir, tx_tgl, tx_word,
                input  tx_ack, rx_tgl, rx_word);
  modport link (input  run, tx_dir, rx_dir, tx_tgl, tx_word,
                output tx_ack, rx_tgl, rx_word);
endinterface // stp_link_if

// File: inc/stp_pkg.sv
// Types shared by the speech test serial port modules.
package stp_pkg;

  // Codes follow the pins: bit 1 is test control line 1, bit 0 is line 2.
  typedef enum logic [1:0] {
    STP_MODE_NORMAL   = 2'h0,
    STP_MODE_DOWNLINK = 2'h1,
    STP_MODE_UPLINK   = 2'h2,
    STP_MODE_ACOUSTIC = 2'h3
  } stp_mode_t;

endpackage

// File: logic/stp_link.sv
// Link-clock side: data clock generation and bit shifting in both directions.
`timescale 1ns/1ps
`include "stp_defines.svh"
module stp_link
  import stp_pkg::*;
#(
  parameter int W    = `STP_SAMPLE_W,
  parameter int HALF = `STP_LINK_HALF
) (
  input  wire logic  i_clk_link,
  input  wire logic  i_rst,
  stp_link_if.link   lif,
  input  wire logic  i_data_from_sim,
  output logic       o_data_clk,
  output logic       o_data_to_sim
);

  localparam int CW = $clog2(HALF + 1);
  localparam int BW = $clog2(W + 1);

  typedef struct packed {
    logic          run_s1;
    logic          run_s2;
    logic          tx_s1;
    logic          tx_s2;
    logic          taken;
    logic          din_s1;
    logic          din_s2;
    logic [CW-1:0] div;
    logic          clk;
    logic          dout;
    logic          busy;
    logic [BW-1:0] bitcnt;
    logic [W-1:0]  sh_tx;
    logic [W-1:0]  sh_rx;
    logic [W-1:0]  rx_word;
    logic          rx_tgl;
  } stp_lnk_t;

  localparam stp_lnk_t LNK_RST = '{clk: `STP_CLK_IDLE, default: '0};

  stp_lnk_t q;
  stp_lnk_t n;

  initial begin
    if (HALF < 2 || W < 2) begin
      $error("stp_link: HALF and W must be at least 2.");
    end
  end

  always_comb begin
    n        = q;
    n.run_s1 = lif.run;
    n.run_s2 = q.run_s1;
    n.tx_s1  = lif.tx_tgl;
    n.tx_s2  = q.tx_s1;
    n.din_s1 = i_data_from_sim;
    n.din_s2 = q.din_s1;
    if (!q.run_s2) begin
      // No pulses while stopped; a word offered meanwhile is dropped and acknowledged.
      n.busy  = 1'b0;
      n.clk   = `STP_CLK_IDLE;
      n.div   = '0;
      n.dout  = 1'b0;
      n.taken = q.tx_s2;
    end else if (!q.busy) begin
      n.clk = `STP_CLK_IDLE;
      // Pulses start only when a word is ready to go out or one is wanted in.
      if (!lif.tx_dir || (q.tx_s2 != q.taken)) begin
        n.busy   = 1'b1;
        n.sh_tx  = lif.tx_dir ? lif.tx_word : '0;
        n.taken  = q.tx_s2;
        n.bitcnt = '0;
        n.div    = '0;
      end
    end else if (q.div == CW'(HALF - 1)) begin
      n.div = '0;
      if (q.clk) begin
        n.clk   = 1'b0;
        n.dout  = q.sh_tx[W-1];
        n.sh_tx = {q.sh_tx[W-2:0], 1'b0};
      end else begin
        n.clk    = 1'b1;
        n.sh_rx  = {q.sh_rx[W-2:0], q.din_s2};
        n.bitcnt = q.bitcnt + BW'(1);
        if (q.bitcnt == BW'(W - 1)) begin
          n.busy = 1'b0;
          if (lif.rx_dir) begin
            n.rx_word = {q.sh_rx[W-2:0], q.din_s2};
            n.rx_tgl  = ~q.rx_tgl;
          end
        end
      end
    end else begin
      n.div = q.div + CW'(1);
    end
  end

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      q <= LNK_RST;
    end else begin
      q <= n;
    end
  end

  assign lif.tx_ack    = q.taken;
  assign lif.rx_tgl    = q.rx_tgl;
  assign lif.rx_word   = q.rx_word;
  assign o_data_clk    = q.clk;
  assign o_data_to_sim = q.dout;

  a_clk_idle_high: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !q.busy |-> q.clk) else $error("Data clock low outside a transfer.");
  a_dout_on_fall: assert property (@(posedge i_clk_link) disable iff (i_rst)
    q.run_s2 && $past(q.run_s2) && $changed(q.dout) |-> $fell(q.clk))
    else $error("Outgoing data changed off a falling edge.");
  a_rx_on_rise: assert property (@(posedge i_clk_link) disable iff (i_rst)
    q.busy && $changed(q.sh_rx) |-> $rose(q.clk))
    else $error("Incoming bit taken off a rising edge.");
  a_msb_first_out: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $rose(q.busy) && lif.tx_dir |=> q.sh_tx[W-1] == $past(lif.tx_word[W-1]))
    else $error("Word not loaded with its top bit first.");
  a_stop_no_pulse: assert property (@(posedge i_clk_link) disable iff (i_rst)
    !q.run_s2 |=> q.clk && !q.busy)
    else $error("Pulses issued while stopped.");
  c_word_done: cover property (@(posedge i_clk_link) disable iff (i_rst)
    $changed(q.rx_tgl));
  c_tx_burst: cover property (@(posedge i_clk_link) disable iff (i_rst)
    $rose(q.busy) && lif.tx_dir);

endmodule // stp_link

// File: logic/stp_top.sv
// Speech test serial port of the handset: mode control, sample handover, crossings.
// How it works
// - Reset pin low means asserted, high released.
// - Samples are 13-bit two's complement, MSB first.
// - Sample on rising edge, change on falling.
// - Data clock stays high when idle.
// - Two control lines select one of four modes.
// - Over-the-air setup may select the mode instead.
// - Clock pulses only when data needed or ready.
// - Uplink: first falling edge requests first bit.
// - Downlink: send samples from frames after release.
// - Reset release in test mode resets transcoders.
// - 8000 samples/s each way at 104 kbit/s.
// - Handset alone drives the data clock.
`timescale 1ns/1ps
`include "stp_defines.svh"
module stp_top
  import stp_pkg::*;
#(
  parameter int SAMPLE_W  = `STP_SAMPLE_W,
  parameter int LINK_HALF = `STP_LINK_HALF
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_clk_link,
  input  wire logic                i_rst,
  input  wire logic                i_test_reset_n,
  input  wire logic                i_test_ctl1,
  input  wire logic                i_test_ctl2,
  input  wire logic                i_ota_sel,
  input  wire logic [1:0]          i_ota_mode,
  input  wire logic                i_frame_blk,
  input  wire logic                i_data_from_sim,
  input  wire logic [SAMPLE_W-1:0] i_dl_sample,
  input  wire logic                i_dl_valid,
  output logic                     o_dl_ready,
  output logic [SAMPLE_W-1:0]      o_ul_sample,
  output logic                     o_ul_valid,
  output logic [1:0]               o_mode,
  output logic                     o_path_internal,
  output logic                     o_xcdr_rst,
  output logic                     o_test_active,
  output logic                     o_data_clk,
  output logic                     o_data_to_sim
);

  typedef struct packed {
    logic                rstn_s1;
    logic                rstn_s2;
    logic                rstn_prev;
    logic [1:0]          ctl_s1;
    logic [1:0]          ctl_s2;
    stp_mode_t           mode;
    logic                active;
    logic                wait_frame;
    logic                xcdr_rst;
    logic                path;
    logic [SAMPLE_W-1:0] tx_word;
    logic                tx_tgl;
    logic                ack_s1;
    logic                ack_s2;
    logic                dl_ready;
    logic                rx_s1;
    logic                rx_s2;
    logic                rx_prev;
    logic [SAMPLE_W-1:0] ul_sample;
    logic                ul_valid;
  } stp_sys_t;

  // The reset pin idles high; its synchroniser starts high so that leaving
  // i_rst is never mistaken for the end of a reset pulse.
  localparam stp_sys_t SYS_RST = '{
    rstn_s1:   1'b1,
    rstn_s2:   1'b1,
    rstn_prev: 1'b1,
    mode:      STP_MODE_NORMAL,
    path:      `STP_PATH_INTERNAL,
    default:   '0
  };

  stp_sys_t   q;
  stp_sys_t   n;
  stp_mode_t  mode_sel;
  logic       release_ev;
  logic       accept_dl;
  logic       tx_dir_d;
  logic       rx_dir_d;

  stp_link_if #(.W(SAMPLE_W)) lif ();

  initial begin
    if (SAMPLE_W < 2 || SAMPLE_W > 32) begin
      $error("stp_top: SAMPLE_W must lie in 2 to 32.");
    end
    if (LINK_HALF < 2) begin
      $error("stp_top: LINK_HALF must be at least 2.");
    end
    if (SAMPLE_W * `STP_SAMPLE_RATE_HZ != `STP_BIT_RATE_HZ) begin
      $error("stp_top: bit rate does not carry the sample rate.");
    end
  end

  always_comb begin
    n         = q;
    n.rstn_s1 = i_test_reset_n;
    n.rstn_s2 = q.rstn_s1;
    n.rstn_prev = q.rstn_s2;
    n.ctl_s1  = {i_test_ctl1, i_test_ctl2};
    n.ctl_s2  = q.ctl_s1;
    n.ack_s1  = lif.tx_ack;
    n.ack_s2  = q.ack_s1;
    n.rx_s1   = lif.rx_tgl;
    n.rx_s2   = q.rx_s1;
    n.rx_prev = q.rx_s2;

    // Over-the-air setup overrides the control lines when it is in charge.
    if (i_ota_sel) begin
      mode_sel = stp_mode_t'(i_ota_mode);
    end else begin
      mode_sel = stp_mode_t'(q.ctl_s2);
    end
    n.mode = mode_sel;

    // A test starts at the low-to-high edge of the reset pin; the mode is
    // expected to be settled long before, so the release uses the current selection mode_sel.
    release_ev = q.rstn_s2 && !q.rstn_prev;
    n.xcdr_rst = release_ev && (mode_sel != STP_MODE_NORMAL);

    if (!q.rstn_s2 || mode_sel == STP_MODE_NORMAL || mode_sel != q.mode) begin
      n.active = 1'b0;
    end else if (release_ev) begin
      n.active = 1'b1;
    end

    // Downlink words come only from frames whose reception ends after release.
    if (release_ev) begin
      n.wait_frame = 1'b1;
    end else if (i_frame_blk || !n.active) begin
      n.wait_frame = 1'b0;
    end
    if (!n.active) begin
      n.wait_frame = release_ev;
    end

    n.path = !n.active;

    tx_dir_d = (n.mode == STP_MODE_DOWNLINK) || (n.mode == STP_MODE_ACOUSTIC);
    rx_dir_d = (n.mode == STP_MODE_UPLINK) || (n.mode == STP_MODE_ACOUSTIC);

    // One word at a time crosses to the link; the toggle stays ahead of the
    // acknowledge until the link has taken the word, which holds it stable.
    accept_dl = q.dl_ready && i_dl_valid;
    if (accept_dl) begin
      n.tx_word = i_dl_sample;
      n.tx_tgl  = ~q.tx_tgl;
    end
    n.dl_ready = n.active && tx_dir_d && !n.wait_frame
                 && (n.tx_tgl == n.ack_s2);

    // Uplink words are passed on as they arrive; the encoder aligns them to
    // the next interleaved block itself.
    n.ul_valid = 1'b0;
    if (q.rx_s2 != q.rx_prev && q.active && rx_dir_d) begin
      n.ul_sample = lif.rx_word;
      n.ul_valid  = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= SYS_RST;
    end else begin
      q <= n;
    end
  end

  // Run, toggle and word handed to the link come from flops of this domain; the direction bits are decoded from the mode flop.
  assign lif.run     = q.active;
  assign lif.tx_dir  = (q.mode == STP_MODE_DOWNLINK) || (q.mode == STP_MODE_ACOUSTIC);
  assign lif.rx_dir  = (q.mode == STP_MODE_UPLINK) || (q.mode == STP_MODE_ACOUSTIC);
  assign lif.tx_tgl  = q.tx_tgl;
  assign lif.tx_word = q.tx_word;

  stp_link #(
    .W    (SAMPLE_W),
    .HALF (LINK_HALF)
  ) u_link (
    .i_clk_link      (i_clk_link),
    .i_rst           (i_rst),
    .lif             (lif),
    .i_data_from_sim (i_data_from_sim),
    .o_data_clk      (o_data_clk),
    .o_data_to_sim   (o_data_to_sim)
  );

  assign o_dl_ready      = q.dl_ready;
  assign o_ul_sample     = q.ul_sample;
  assign o_ul_valid      = q.ul_valid;
  assign o_mode          = q.mode;
  assign o_path_internal = q.path;
  assign o_xcdr_rst      = q.xcdr_rst;
  assign o_test_active   = q.active;

  a_xcdr_on_release: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    q.rstn_s2 && !q.rstn_prev && (n.mode != STP_MODE_NORMAL) |=> o_xcdr_rst ##1 !o_xcdr_rst)
    else $error("Transcoder reset missing at release.");
  a_ctl_mode_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_ota_sel |=> o_mode == $past(q.ctl_s2))
    else $error("Mode does not follow the control lines.");
  a_ota_mode_map: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_ota_sel |=> o_mode == $past(i_ota_mode))
    else $error("Mode does not follow the air setup.");
  a_reset_low_stops: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !q.rstn_s2 |=> !o_test_active && o_path_internal)
    else $error("Test active while reset pin is low.");
  a_normal_internal: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_mode == STP_MODE_NORMAL |-> o_path_internal && !o_test_active)
    else $error("Normal mode not on internal paths.");
  a_frame_gates_dl: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    q.wait_frame |-> !o_dl_ready)
    else $error("Downlink word taken before a fresh frame.");
  a_ul_only_rx: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_ul_valid |-> $past(q.active) && o_mode != STP_MODE_DOWNLINK ##1 !o_ul_valid)
    else $error("Uplink word outside an uplink mode.");
  a_one_word_flight: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_dl_ready && i_dl_valid |=> !o_dl_ready [*2])
    else $error("Second word accepted before acknowledge.");

  c_uplink_word: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_ul_valid && o_mode == STP_MODE_UPLINK);
  c_downlink_word: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_dl_ready && i_dl_valid);
  c_acoustic_start: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_xcdr_rst && o_mode == STP_MODE_ACOUSTIC);

endmodule // stp_top

// File: testbench/speech_codec_test_serial_port_tb_top.sv
// Self-checking testbench of the speech test serial port.
`timescale 1ns/1ps
module speech_codec_test_serial_port_tb_top;
  import stp_pkg::*;
  localparam int HALF = 4;

  logic        i_clk_sys, i_clk_link, i_rst, i_test_reset_n, i_test_ctl1, i_test_ctl2;
  logic        i_ota_sel, i_frame_blk, i_data_from_sim, i_dl_valid;
  logic [1:0]  i_ota_mode, o_mode;
  logic [12:0] i_dl_sample, o_ul_sample, sim_word, rx_word;
  logic        o_dl_ready, o_ul_valid, o_path_internal, o_xcdr_rst, o_test_active;
  logic        o_data_clk, o_data_to_sim, saw, bad;
  logic [7:0]  rx_n, sim_err, n0;
  int          n_mismatch, n_checks;

  stp_top #(.SAMPLE_W(13), .LINK_HALF(HALF)) dut_u (
    .i_clk_sys(i_clk_sys), .i_clk_link(i_clk_link), .i_rst(i_rst),
    .i_test_reset_n(i_test_reset_n), .i_test_ctl1(i_test_ctl1), .i_test_ctl2(i_test_ctl2),
    .i_ota_sel(i_ota_sel), .i_ota_mode(i_ota_mode), .i_frame_blk(i_frame_blk),
    .i_data_from_sim(i_data_from_sim), .i_dl_sample(i_dl_sample), .i_dl_valid(i_dl_valid),
    .o_dl_ready(o_dl_ready), .o_ul_sample(o_ul_sample), .o_ul_valid(o_ul_valid),
    .o_mode(o_mode), .o_path_internal(o_path_internal), .o_xcdr_rst(o_xcdr_rst),
    .o_test_active(o_test_active), .o_data_clk(o_data_clk), .o_data_to_sim(o_data_to_sim));

  stp_sim_model sim_u (
    .i_data_clk(o_data_clk), .i_data_to_sim(o_data_to_sim), .i_test_reset_n(i_test_reset_n),
    .i_word(sim_word), .o_data(i_data_from_sim), .o_rx_word(rx_word), .o_rx_n(rx_n),
    .o_err(sim_err));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  initial begin
    i_clk_link = 1'b0;
    #3.7;
    forever #24 i_clk_link = ~i_clk_link;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD t=%0t %s", $time, msg);
    end
  endtask

  task automatic set_mode(input logic [1:0] m);
    i_test_ctl1 = m[1];
    i_test_ctl2 = m[0];
    cyc(8);
  endtask

  // Mode is already set; the simulator then pulses its reset pin low.
  task automatic pulse_rst(output logic s);
    s = 1'b0;
    i_test_reset_n = 1'b0;
    cyc(10);
    i_test_reset_n = 1'b1;
    repeat (10) begin
      cyc(1);
      if (o_xcdr_rst === 1'b1) s = 1'b1;
    end
  endtask

  task automatic quiet(input int n, output logic b);
    b = 1'b0;
    repeat (n) begin
      cyc(1);
      if (o_data_clk !== 1'b1) b = 1'b1;
    end
  endtask

  task automatic t_idle;
    chk(o_data_clk === 1'b1, "clock not idle high");
    chk(o_path_internal === 1'b1 && o_test_active === 1'b0, "not internal");
    chk(o_mode === STP_MODE_NORMAL, "mode after reset");
    $display("test idle done");
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      set_mode(2'(m));
      chk(o_mode === 2'(m), "line mode decode");
    end
    set_mode(STP_MODE_NORMAL);
    i_ota_sel  = 1'b1;
    i_ota_mode = STP_MODE_UPLINK;
    cyc(4);
    chk(o_mode === STP_MODE_UPLINK, "air setup mode");
    i_ota_sel = 1'b0;
    cyc(4);
    $display("test modes done");
  endtask

  task automatic t_normal;
    set_mode(STP_MODE_NORMAL);
    pulse_rst(saw);
    chk(saw === 1'b0 && o_test_active === 1'b0, "test in normal mode");
    quiet(200, bad);
    chk(bad === 1'b0, "clock pulses in normal mode");
    $display("test normal done");
  endtask

  task automatic t_uplink;
    sim_word = 13'h1a5c;
    set_mode(STP_MODE_UPLINK);
    pulse_rst(saw);
    chk(saw === 1'b1, "no transcoder reset");
    chk(o_test_active === 1'b1 && o_path_internal === 1'b0, "test not started");
    for (int k = 0; k < 3000 && o_ul_valid !== 1'b1; k++) cyc(1);
    chk(o_ul_valid === 1'b1 && o_ul_sample === 13'h1a5c, "first uplink word");
    sim_word = 13'h1001;
    repeat (2) begin
      cyc(1);
      for (int k = 0; k < 3000 && o_ul_valid !== 1'b1; k++) cyc(1);
    end
    chk(o_ul_sample === 13'h1001, "negative uplink word");
    set_mode(STP_MODE_DOWNLINK);
    chk(o_test_active === 1'b0, "mode change keeps test");
    cyc(700);
    quiet(200, bad);
    chk(bad === 1'b0, "clock runs after stop");
    $display("test uplink done");
  endtask

  task automatic t_downlink;
    pulse_rst(saw);
    chk(saw === 1'b1, "no transcoder reset");
    cyc(20);
    chk(o_dl_ready === 1'b0, "ready before frame");
    quiet(100, bad);
    chk(bad === 1'b0, "clock without data");
    i_frame_blk = 1'b1;
    cyc(1);
    i_frame_blk = 1'b0;
    for (int k = 0; k < 50 && o_dl_ready !== 1'b1; k++) cyc(1);
    chk(o_dl_ready === 1'b1, "no ready after frame");
    n0 = rx_n;
    i_dl_sample = 13'h1c35;
    i_dl_valid  = 1'b1;
    cyc(1);
    i_dl_valid = 1'b0;
    for (int k = 0; k < 3000 && rx_n === n0; k++) cyc(1);
    chk(rx_word === 13'h1c35, "downlink word");
    quiet(200, bad);
    chk(bad === 1'b0, "clock after burst");
    chk(sim_err === 8'h00, "data moved before rise");
    set_mode(STP_MODE_ACOUSTIC);
    pulse_rst(saw);
    chk(saw === 1'b1 && o_test_active === 1'b1, "acoustic test not started");
    chk(o_path_internal === 1'b0 && o_dl_ready === 1'b0, "acoustic path or ready");
    $display("test downlink done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    n_mismatch = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_test_reset_n = 1'b1;
    i_test_ctl1 = 1'b0;
    i_test_ctl2 = 1'b0;
    i_ota_sel = 1'b0;
    i_ota_mode = 2'h0;
    i_frame_blk = 1'b0;
    i_dl_valid = 1'b0;
    i_dl_sample = 13'h0000;
    sim_word = 13'h0000;
    repeat (6) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    cyc(4);
    t_idle;
    t_modes;
    t_normal;
    t_uplink;
    t_downlink;
    give_verdict;
  end
endmodule // speech_codec_test_serial_port_tb_top

// File: testbench/stp_sim_model.sv
// Behavioural model of the system simulator on the serial data lines.
`timescale 1ns/1ps
module stp_sim_model (
  input  wire logic        i_data_clk,
  input  wire logic        i_data_to_sim,
  input  wire logic        i_test_reset_n,
  input  wire logic [12:0] i_word,
  output logic             o_data,
  output logic [12:0]      o_rx_word,
  output logic [7:0]       o_rx_n,
  output logic [7:0]       o_err
);
  int          n_fall;
  int          n_rise;
  logic [12:0] shift;
  logic        at_fall;

  initial begin
    o_data    = 1'b0;
    o_rx_word = '0;
    o_rx_n    = '0;
    o_err     = '0;
    n_fall    = 0;
    n_rise    = 0;
    shift     = '0;
    at_fall   = 1'b0;
  end

  // A falling edge on the reset pin restarts the word framing.
  always @(negedge i_test_reset_n) begin
    n_fall = 0;
    n_rise = 0;
  end

  // Only the data line is driven here; the clock belongs to the handset.
  always @(negedge i_data_clk) begin
    o_data <= i_word[12 - n_fall];
    n_fall = (n_fall + 1) % 13;
    #1 at_fall = i_data_to_sim;
  end

  always @(posedge i_data_clk) begin
    if (i_data_to_sim !== at_fall) begin
      o_err <= o_err + 8'h01;
    end
    shift = {shift[11:0], i_data_to_sim};
    n_rise = (n_rise + 1) % 13;
    if (n_rise == 0) begin
      o_rx_word <= shift;
      o_rx_n    <= o_rx_n + 8'h01;
      // Hold time over: the line no longer shows the last bit.
      #60 o_data <= ~o_data;
    end
  end
endmodule // stp_sim_model
